// ---- fan_acoustic_ramp_control_tb.sv ----
// self-checking bench of the acoustic ramp block
`timescale 1ns/1ps
`default_nettype none
module fan_acoustic_ramp_control_tb;
   localparam logic [9:0] A_CTRL = 10'h188;
   localparam logic [9:0] A_CFG = 10'h1C0;
   localparam logic [9:0] A_SRC = 10'h1C4;
   localparam logic [7:0] STEPS [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h30};
   logic hclk, hresetn, ce, hsel, hwrite, hrdata_dummy;
   logic [9:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize, below_low, speed_sync;
   logic [31:0] hwdata, hrdata, q;
   logic hreadyout, hresp;
   logic [7:0] remote1_duty, fan_drive_1, fan_drive_2, fan_drive_3;
   logic [23:0] alt_duty, fan_speed;
   int errors, compares, n;
   far_top #(.SLOT_FAST_CYC(32'h4), .SLOT_SCALED_CYC(32'h6), .ADDR_W(10)) u_far_top (.hclk(hclk), .hresetn(hresetn), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .remote1_duty(remote1_duty), .below_low(below_low),
      .alt_duty(alt_duty), .fan_drive_1(fan_drive_1), .fan_drive_2(fan_drive_2), .fan_drive_3(fan_drive_3),
      .speed_sync(speed_sync));
   far_fan_model u_far_fan_model (.hclk(hclk), .hresetn(hresetn), .fan_drive_1(fan_drive_1), .fan_drive_2(fan_drive_2),
      .fan_drive_3(fan_drive_3), .fan_speed(fan_speed));
   // clock
   always #5 hclk = ~hclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one single transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'h2; haddr <= a; hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0; hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      q = hrdata;
   endtask
   task automatic settle();
      repeat (6) @(posedge hclk);
   endtask
   task automatic wait_change();
      logic [7:0] v;
      v = fan_drive_1;
      n = 0;
      do begin @(posedge hclk); n++; end while (fan_drive_1 === v && n < 300);
   endtask
   task automatic t_reset();
      bus(1'b0, A_CTRL, 32'h0); chk(q, 32'h0);
      bus(1'b0, 10'h000, 32'h0); chk(q, 32'h0);
      chk(speed_sync, 3'h6);
      $display("test reset done");
   endtask
   task automatic t_sync();
      bus(1'b1, A_CTRL, 32'h10); settle(); chk(speed_sync, 3'h7);
      bus(1'b1, A_CTRL, 32'h00); settle(); chk(speed_sync, 3'h6);
      $display("test sync done");
   endtask
   task automatic t_floor();
      bus(1'b1, A_SRC, 32'h049); below_low <= 3'h7; alt_duty <= 24'h332211;
      for (int f = 0; f < 2; f++) begin
         bus(1'b1, A_CTRL, f ? 32'hE0 : 32'h00); settle();
         chk(fan_drive_1, f ? 8'h80 : 8'h00);
         chk(fan_drive_2, f ? 8'h80 : 8'h00);
         chk(fan_drive_3, f ? 8'h80 : 8'h00);
      end
      below_low <= 3'h0; settle();
      chk({fan_drive_3, fan_drive_2, fan_drive_1}, 24'h332211);
      chk(fan_speed, 24'h332211);
      $display("test floor done");
   endtask
   task automatic t_ramp();
      bus(1'b1, A_SRC, 32'h000);
      for (int k = 0; k < 8; k++) begin
         remote1_duty <= 8'h00; bus(1'b1, A_CTRL, 32'h0); settle();
         chk(fan_drive_1, 8'h00);
         bus(1'b1, A_CTRL, 32'h8 | k); remote1_duty <= 8'hC0;
         wait_change(); chk(fan_drive_1, STEPS[k]);
      end
      $display("test ramp done");
   endtask
   task automatic t_scale();
      remote1_duty <= 8'h00; bus(1'b1, A_CTRL, 32'h0); settle();
      bus(1'b1, A_CFG, 32'h2); bus(1'b1, A_CTRL, 32'h8); remote1_duty <= 8'hFF;
      wait_change(); wait_change(); chk(n, 32'd6);
      bus(1'b1, A_CFG, 32'h4);
      wait_change(); wait_change(); chk(n, 32'd16);
      $display("test scale done");
   endtask
   task automatic t_lock();
      bus(1'b1, A_CTRL, 32'h5A); bus(1'b1, A_CFG, 32'h1); bus(1'b1, A_CTRL, 32'hA5);
      bus(1'b0, A_CTRL, 32'h0); chk(q, 32'h5A);
      hresetn <= 1'b0; repeat (10) @(posedge hclk); hresetn <= 1'b1; @(posedge hclk);
      bus(1'b0, A_CTRL, 32'h0); chk(q, 32'h0);
      bus(1'b1, A_CTRL, 32'h24); bus(1'b0, A_CTRL, 32'h0); chk(q, 32'h24);
      $display("test lock done");
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence
   initial begin
      hclk = 1'b0; hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; hwrite = 1'b0; hrdata_dummy = 1'b0;
      haddr = 10'h000; htrans = 2'h0; hsize = 3'h2; hwdata = 32'h0; remote1_duty = 8'h00;
      below_low = 3'h0; alt_duty = 24'h000000; errors = 0; compares = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset(); t_sync(); t_floor(); t_ramp(); t_scale(); t_lock();
      report_and_stop();
   end
   // watchdog
   initial begin
      #1000000;
      errors++;
      report_and_stop();
   end
endmodule // fan_acoustic_ramp_control_tb
`default_nettype wire

// ---- far_defines.vh ----
// offsets, fields, reset values and timing counts of the acoustic ramp block
`ifndef FAR_DEFINES_VH
`define FAR_DEFINES_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define FAR_IDX_ACOU1 8'h62
`define FAR_IDX_CFG 8'h70
`define FAR_IDX_SRC 8'h71
`define FAR_IDX_OUT1_FLOOR_SEL 8'h72
`define FAR_IDX_OUT2_FLOOR_SEL 8'h73
`define FAR_IDX_OUT3_FLOOR_SEL 8'h74
`define FAR_IDX_STAT 8'h75

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define FAR_RATE_LSB 0
`define FAR_RATE_MSB 2
`define FAR_SMOOTH_BIT 3
`define FAR_SYNC_BIT 4
`define FAR_FLOOR1_BIT 5
`define FAR_FLOOR2_BIT 6
`define FAR_FLOOR3_BIT 7
`define FAR_CFG_LOCK_BIT 0
`define FAR_CFG_SCALE_BIT 1
`define FAR_CFG_SLOW_BIT 2

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FAR_ACOU1_RST 8'h00
`define FAR_CFG_RST 3'h0
`define FAR_SRC_RST 9'h0DB
`define FAR_MIN_RST 8'h80

// ----------------------------------------------------------------------
// drive source codes
// ----------------------------------------------------------------------
`define FAR_SRC_REMOTE1 3'h0
`define FAR_SRC_LOCAL 3'h1
`define FAR_SRC_REMOTE2 3'h2
`define FAR_SRC_FULL 3'h3
`define FAR_SRC_OFF 3'h4
`define FAR_SRC_FAST_LR2 3'h5
`define FAR_SRC_FAST_ALL 3'h6
`define FAR_SRC_MANUAL 3'h7

// ----------------------------------------------------------------------
// timing: full 0 to 100 percent ramp at one step per slot, in ms
// ----------------------------------------------------------------------
`define FAR_FULL_RAMP_FAST_MS 37500
`define FAR_FULL_RAMP_SCALED_MS 52200
`define FAR_CLK_KHZ 100000
`define FAR_DUTY_STEPS 255
`define FAR_SLOW_FACTOR 4
// full ramp time in cycles divided by 255 duty steps, rounded down
`define FAR_SLOT_FAST_CYC 32'd14705882
`define FAR_SLOT_SCALED_CYC 32'd20470588

`endif

// ---- far_fan_model.sv ----
// behavioural fans whose speed trails the drive duty
`timescale 1ns/1ps
`default_nettype none
module far_fan_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [7:0] fan_drive_1,
   input wire logic [7:0] fan_drive_2,
   input wire logic [7:0] fan_drive_3,
   output var logic [23:0] fan_speed
);
   // each rotor speed follows its drive duty one cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fan_speed <= 24'h000000;
      end else begin
         fan_speed <= {fan_drive_3, fan_drive_2, fan_drive_1};
      end
   end
endmodule // far_fan_model
`default_nettype wire

// ---- far_out_sel.v ----
// per-output duty choice with low-limit floor, and tach sync mask
`timescale 1ns/1ps
`default_nettype none
module far_out_sel (
   input wire hclk,
   input wire hresetn,
   input wire ce,
   input wire [8:0] src,
   input wire [2:0] floor_sel,
   input wire [2:0] below_low,
   input wire [7:0] ramp_duty,
   input wire [23:0] alt_duty,
   input wire [23:0] min_duty,
   input wire sync_sel,
   output reg [23:0] duty,
   output reg [2:0] tach_sync
);
`include "far_defines.vh"
   // ----------------------------------------------------------------------
   // per-output selection
   // ----------------------------------------------------------------------
   function [7:0] far_pick;
      input [2:0] code;
      input fl;
      input low;
      input [7:0] ramp;
      input [7:0] alt;
      input [7:0] mind;
      reg auto;
      reg [7:0] raw;
      begin
         auto = 1'b0;
         raw = alt;
         case (code)
            `FAR_SRC_REMOTE1: begin
               auto = 1'b1;
               raw = ramp;
            end
            `FAR_SRC_FULL: raw = 8'hFF;
            `FAR_SRC_OFF: raw = 8'h00;
            `FAR_SRC_MANUAL: raw = alt;
            default: auto = 1'b1;
         endcase
         if (auto && low) begin
            far_pick = fl ? mind : 8'h00;
         end else begin
            far_pick = raw;
         end
      end
   endfunction

   // register each output's duty and the sync mask
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         duty <= 24'h000000;
         tach_sync <= 3'h0;
      end else if (ce) begin
         duty[7:0] <= far_pick(src[2:0], floor_sel[0], below_low[0],
                               ramp_duty, alt_duty[7:0], min_duty[7:0]);
         duty[15:8] <= far_pick(src[5:3], floor_sel[1], below_low[1],
                                ramp_duty, alt_duty[15:8], min_duty[15:8]);
         duty[23:16] <= far_pick(src[8:6], floor_sel[2], below_low[2],
                                 ramp_duty, alt_duty[23:16],
                                 min_duty[23:16]);
         // bit0 speed_in_2, bit1 speed_in_3, bit2 speed_in_4
         tach_sync <= sync_sel ? 3'h7 : 3'h6;
      end
   end
endmodule // far_out_sel
`default_nettype wire

// ---- far_ramp.v ----
// duty ramp limiter for the remote-1 channel
`timescale 1ns/1ps
`default_nettype none
module far_ramp (
   input wire hclk,
   input wire hresetn,
   input wire ce,
   input wire smooth_en,
   input wire slot_tick,
   input wire [7:0] step,
   input wire [7:0] target,
   output reg [7:0] duty
);
   // ----------------------------------------------------------------------
   // step logic
   // ----------------------------------------------------------------------
   reg [7:0] next_duty;
   wire [7:0] gap_up;
   wire [7:0] gap_dn;
   assign gap_up = target - duty;
   assign gap_dn = duty - target;

   // move toward target by at most one step per slot
   always @* begin
      next_duty = duty;
      if (!smooth_en) begin
         next_duty = target;
      end else if (slot_tick) begin
         if (target > duty) begin
            next_duty = (gap_up > step) ? duty + step : target;
         end else if (target < duty) begin
            next_duty = (gap_dn > step) ? duty - step : target;
         end
      end
   end

   // duty register
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         duty <= 8'h00;
      end else if (ce) begin
         duty <= next_duty;
      end
   end
endmodule // far_ramp
`default_nettype wire

// ---- far_top.v ----
// acoustic ramp control register block with AHB-Lite slave
//
// Function
// - remote-1 ramp rate limited by selector
// - duty approaches new target gradually
// - unscaled steps 1..48, 37.5 s to 0.8 s
// - scaled ramps slower, 52.2 s to 1.1 s
// - smoothing only while smooth enable set
// - sync one: speed inputs 2-4 synced
// - sync zero: only speed inputs 3-4 synced
// - output 1 floor: off or minimum duty
// - output 2 floor: off or minimum duty
// - lock set makes register ignore writes
// - slow-down bit makes ramps four times slower
// - register resets to zero at power-on
// - source code zero ties output to remote-1
`timescale 1ns/1ps
`default_nettype none
`include "far_defines.vh"
module far_top #(
   parameter [31:0] SLOT_FAST_CYC = `FAR_SLOT_FAST_CYC,
   parameter [31:0] SLOT_SCALED_CYC = `FAR_SLOT_SCALED_CYC,
   parameter ADDR_W = 10
) (
   input wire hclk,
   input wire hresetn,
   input wire ce,
   input wire hsel,
   input wire [ADDR_W-1:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire [7:0] remote1_duty,
   input wire [2:0] below_low,
   input wire [23:0] alt_duty,
   output reg [7:0] fan_drive_1,
   output reg [7:0] fan_drive_2,
   output reg [7:0] fan_drive_3,
   output reg [2:0] speed_sync
);
   // ----------------------------------------------------------------------
   // helper functions
   // ----------------------------------------------------------------------
   // time-slot increase for each selector code
   function [7:0] far_step;
      input [2:0] code;
      begin
         case (code)
            3'h0: far_step = 8'h01;
            3'h1: far_step = 8'h02;
            3'h2: far_step = 8'h03;
            3'h3: far_step = 8'h04;
            3'h4: far_step = 8'h08;
            3'h5: far_step = 8'h0C;
            3'h6: far_step = 8'h18;
            default: far_step = 8'h30;
         endcase
      end
   endfunction

   // register index from a byte address
   function [7:0] far_index;
      input [ADDR_W-1:0] a;
      begin
         far_index = a[9:2];
      end
   endfunction

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   reg [7:0] acoustic_ramp_ctrl_1;
   reg [2:0] cfg;
   reg [8:0] src;
   reg [7:0] out1_floor_sel;
   reg [7:0] out2_floor_sel;
   reg [7:0] out3_floor_sel;

   // ----------------------------------------------------------------------
   // AHB-Lite address phase capture
   // ----------------------------------------------------------------------
   reg dp_write;
   reg [7:0] dp_index;
   wire take;
   wire [7:0] ap_index;
   reg [31:0] next_rdata;
   wire [23:0] duty_all;
   wire [2:0] tach_sync;
   wire [7:0] ramp_duty;

   assign take = hsel & hready & htrans[1];
   assign ap_index = far_index(haddr);

   // read data chosen at the address phase so it stands in the data phase
   always @* begin
      next_rdata = 32'h00000000;
      case (ap_index)
         `FAR_IDX_ACOU1: next_rdata = {24'h000000, acoustic_ramp_ctrl_1};
         `FAR_IDX_CFG: next_rdata = {29'h00000000, cfg};
         `FAR_IDX_SRC: next_rdata = {23'h000000, src};
         `FAR_IDX_OUT1_FLOOR_SEL: next_rdata = {24'h000000, out1_floor_sel};
         `FAR_IDX_OUT2_FLOOR_SEL: next_rdata = {24'h000000, out2_floor_sel};
         `FAR_IDX_OUT3_FLOOR_SEL: next_rdata = {24'h000000, out3_floor_sel};
         `FAR_IDX_STAT: next_rdata = {8'h00, duty_all};
         default: next_rdata = 32'h00000000;
      endcase
   end

   // bus response: zero wait states, always OKAY
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_write <= 1'b0;
         dp_index <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dp_write <= take & hwrite;
         if (take) begin
            dp_index <= ap_index;
         end
         if (take && !hwrite) begin
            hrdata <= next_rdata;
         end
      end
   end

   // ----------------------------------------------------------------------
   // register writes in the data phase
   // ----------------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acoustic_ramp_ctrl_1 <= `FAR_ACOU1_RST;
         cfg <= `FAR_CFG_RST;
         src <= `FAR_SRC_RST;
         out1_floor_sel <= `FAR_MIN_RST;
         out2_floor_sel <= `FAR_MIN_RST;
         out3_floor_sel <= `FAR_MIN_RST;
      end else if (ce && dp_write) begin
         case (dp_index)
            `FAR_IDX_ACOU1: begin
               if (!cfg[`FAR_CFG_LOCK_BIT]) begin
                  acoustic_ramp_ctrl_1 <= hwdata[7:0];
               end
            end
            `FAR_IDX_CFG: begin
               // lock stays set until reset once written
               cfg[`FAR_CFG_LOCK_BIT] <= cfg[`FAR_CFG_LOCK_BIT] |
                                         hwdata[`FAR_CFG_LOCK_BIT];
               cfg[`FAR_CFG_SCALE_BIT] <= hwdata[`FAR_CFG_SCALE_BIT];
               cfg[`FAR_CFG_SLOW_BIT] <= hwdata[`FAR_CFG_SLOW_BIT];
            end
            `FAR_IDX_SRC: src <= hwdata[8:0];
            `FAR_IDX_OUT1_FLOOR_SEL: out1_floor_sel <= hwdata[7:0];
            `FAR_IDX_OUT2_FLOOR_SEL: out2_floor_sel <= hwdata[7:0];
            `FAR_IDX_OUT3_FLOOR_SEL: out3_floor_sel <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // ramp time-slot generator
   // ----------------------------------------------------------------------
   reg [33:0] slot_cnt;
   reg slot_tick;
   wire [33:0] slot_base;
   wire [33:0] slot_len;

   // scale bit picks the slower slot, slow-down bit makes it four times
   assign slot_base = cfg[`FAR_CFG_SCALE_BIT] ?
                      {2'b00, SLOT_SCALED_CYC} :
                      {2'b00, SLOT_FAST_CYC};
   assign slot_len = cfg[`FAR_CFG_SLOW_BIT] ?
                     {slot_base[31:0], 2'b00} : slot_base;

   // one tick per slot; the step size sets the ramp time
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         slot_cnt <= 34'h000000000;
         slot_tick <= 1'b0;
      end else if (ce) begin
         if (slot_cnt + 34'h000000001 >= slot_len) begin
            slot_cnt <= 34'h000000000;
            slot_tick <= 1'b1;
         end else begin
            slot_cnt <= slot_cnt + 34'h000000001;
            slot_tick <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // remote-1 ramp limiter
   // ----------------------------------------------------------------------
   far_ramp u_ramp (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .smooth_en(acoustic_ramp_ctrl_1[`FAR_SMOOTH_BIT]),
      .slot_tick(slot_tick),
      .step(far_step(acoustic_ramp_ctrl_1[2:0])),
      .target(remote1_duty),
      .duty(ramp_duty)
   );

   // ----------------------------------------------------------------------
   // output selection with floor and tach sync
   // ----------------------------------------------------------------------
   far_out_sel u_sel (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .src(src),
      .floor_sel(acoustic_ramp_ctrl_1[7:5]),
      .below_low(below_low),
      .ramp_duty(ramp_duty),
      .alt_duty(alt_duty),
      .min_duty({out3_floor_sel, out2_floor_sel, out1_floor_sel}),
      .sync_sel(acoustic_ramp_ctrl_1[`FAR_SYNC_BIT]),
      .duty(duty_all),
      .tach_sync(tach_sync)
   );

   // ----------------------------------------------------------------------
   // output registers
   // ----------------------------------------------------------------------
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fan_drive_1 <= 8'h00;
         fan_drive_2 <= 8'h00;
         fan_drive_3 <= 8'h00;
         speed_sync <= 3'h0;
      end else if (ce) begin
         fan_drive_1 <= duty_all[7:0];
         fan_drive_2 <= duty_all[15:8];
         fan_drive_3 <= duty_all[23:16];
         speed_sync <= tach_sync;
      end
   end
endmodule // far_top
`default_nettype wire

// ---- far_top_assertions.sv ----
// port checker of the acoustic ramp block
`timescale 1ns/1ps
`default_nettype none
module far_top_assertions #(parameter ADDR_W = 10) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [7:0] remote1_duty,
   input wire logic [2:0] below_low,
   input wire logic [7:0] fan_drive_1,
   input wire logic [2:0] speed_sync
);
   localparam [ADDR_W-1:0] A_CTRL = 10'h188;
   localparam [ADDR_W-1:0] A_CFG = 10'h1C0;
   localparam [ADDR_W-1:0] A_SRC = 10'h1C4;
   logic wp, rp, lock;
   logic [ADDR_W-1:0] wa, ra;
   logic [7:0] ctrl, age;
   logic [8:0] src;
   logic [2:0] bl_q;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   function automatic logic [7:0] step_of(input logic [2:0] c);
      case (c)
         3'h0: step_of = 8'h01;
         3'h1: step_of = 8'h02;
         3'h2: step_of = 8'h03;
         3'h3: step_of = 8'h04;
         3'h4: step_of = 8'h08;
         3'h5: step_of = 8'h0C;
         3'h6: step_of = 8'h18;
         default: step_of = 8'h30;
      endcase
   endfunction
   // shadow of the bus writes; age counts cycles of quiet settings
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp <= 1'b0; rp <= 1'b0; lock <= 1'b0; wa <= '0; ra <= '0;
         ctrl <= 8'h00; src <= 9'h0DB; age <= 8'h00; bl_q <= 3'h0;
      end else if (ce) begin
         wp <= hsel && hready && htrans[1] && hwrite;
         rp <= hsel && hready && htrans[1] && !hwrite;
         wa <= haddr;
         ra <= haddr;
         bl_q <= below_low;
         age <= (wp || below_low != bl_q) ? 8'h00 : age + {7'h0, age != 8'hFF};
         if (wp && wa == A_CTRL && !lock) ctrl <= hwdata[7:0];
         if (wp && wa == A_CFG && hwdata[0]) lock <= 1'b1;
         if (wp && wa == A_SRC) src <= hwdata[8:0];
      end
   end
   ready_always_a: assert property (hreadyout)
      else $error("bus stalled");
   resp_okay_a: assert property (hreadyout |-> !hresp)
      else $error("error response seen");
   reset_values_a: assert property ($rose(hresetn) |-> fan_drive_1 == 8'h00 && hrdata == 32'h0)
      else $error("outputs not cleared by reset");
   ctrl_read_a: assert property (rp && ra == A_CTRL && !wp |-> hrdata == {24'h0, ctrl})
      else $error("control register read back wrong");
   sync_mask_a: assert property (age >= 8'd3 |-> speed_sync == {2'b11, ctrl[4]})
      else $error("speed sync mask wrong");
   floor_off_a: assert property (age >= 8'd4 && src[2:0] == 3'h1 && below_low[0] && !ctrl[5] |-> fan_drive_1 == 8'h00)
      else $error("drive 1 not off below low limit");
   floor_min_a: assert property (age >= 8'd4 && src[2:0] == 3'h1 && below_low[0] && ctrl[5] |-> fan_drive_1 == 8'h80)
      else $error("drive 1 not at minimum below low limit");
   follow_a: assert property (age >= 8'd6 && src[2:0] == 3'h0 && !ctrl[3] |-> fan_drive_1 == $past(remote1_duty, 3))
      else $error("unsmoothed drive does not follow target");
   ramp_step_a: assert property (age >= 8'd6 && src[2:0] == 3'h0 && ctrl[3] |-> fan_drive_1 - $past(fan_drive_1) <= step_of(ctrl[2:0]) || $past(fan_drive_1) - fan_drive_1 <= step_of(ctrl[2:0]))
      else $error("drive moved faster than ramp step");
endmodule // far_top_assertions
bind far_top far_top_assertions #(.ADDR_W(ADDR_W)) u_far_top_assertions (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .remote1_duty(remote1_duty), .below_low(below_low), .fan_drive_1(fan_drive_1), .speed_sync(speed_sync));
`default_nettype wire
